// ---- pkg/sdram_pkg.sv ----
// Package: types and constants for the SDRAM pin interface and init logic.
package sdram_pkg;
    localparam int ROW_W = 12;
    localparam int COL_W = 8;
    localparam int BANK_W = 2;
    localparam int NBANK = 4;
    localparam int DQ_W = 32;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int BEAT_W = 9;
    // Address bit that selects all banks on a precharge, or auto precharge.
    localparam int PRE_ALL_BIT = 10;
    // Mode register field positions on the address lines.
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_WB_BIT = 9;
    localparam int MR_CODE_W = 3;
    localparam logic [2:0] CL_TWO = 3'h2;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [2:0] BL_MAX_POW = 3'h3;
    localparam logic [BEAT_W-1:0] PAGE_LEN = 9'h100;
    localparam logic [3:0] INIT_REFRESHES = 4'h8;
    // Strobe encodings {row, column, write}, all active low.
    localparam logic [2:0] ENC_NOP = 3'h7;
    localparam logic [2:0] ENC_ACT = 3'h3;
    localparam logic [2:0] ENC_READ = 3'h5;
    localparam logic [2:0] ENC_WRITE = 3'h4;
    localparam logic [2:0] ENC_BST = 3'h6;
    localparam logic [2:0] ENC_PRE = 3'h2;
    localparam logic [2:0] ENC_REF = 3'h1;
    localparam logic [2:0] ENC_MRS = 3'h0;

    typedef struct packed {
        logic cs_b;
        logic ras_b;
        logic cas_b;
        logic we_b;
    } cmd_pins_t;

    typedef enum logic [3:0] {
        C_DESEL, C_NOP, C_ACT, C_READ, C_WRITE, C_BST, C_PRE, C_REF, C_MRS
    } cmd_t;

    typedef struct packed {
        logic [2:0] bl;
        logic ilv;
        logic [2:0] cl;
        logic wr_single;
    } mode_t;

    typedef struct packed {
        logic cke_q;
        logic pd;
        logic sr;
        mode_t mode;
        logic mode_valid;
        logic [NBANK-1:0] bank_open;
        logic [NBANK-1:0][ROW_W-1:0] open_row;
        logic rd_act;
        logic wr_act;
        logic bap;
        logic [BANK_W-1:0] bbank;
        logic [COL_W-1:0] bcol;
        logic [COL_W-1:0] beat;
        logic [1:0] pv;
        logic [1:0][DQ_W-1:0] pipe;
        logic vout;
        logic [DQ_W-1:0] dout;
        logic [LANES-1:0] dqm_q;
        logic [LANES-1:0] oe_b;
        logic pre_all_seen;
        logic mrs_seen;
        logic [3:0] ref_cnt;
        logic init_done;
    } dev_state_t;

    localparam dev_state_t ST_RST = '{oe_b: 4'hf, default: '0};
endpackage

// ---- design/cmd_decode.sv ----
// Command decoder: turns chip select and the three strobes into a command.
`timescale 1ns/100ps
module cmd_decode (
    input wire sdram_pkg::cmd_pins_t pins,
    output sdram_pkg::cmd_t cmd
);
    import sdram_pkg::*;

    // A deselected device sees no command at all.
    always_comb begin
        if (pins.cs_b) begin
            cmd = C_DESEL; // [R10]
        end else begin
            case ({pins.ras_b, pins.cas_b, pins.we_b}) // [R11]
                ENC_NOP: cmd = C_NOP;
                ENC_ACT: cmd = C_ACT;
                ENC_READ: cmd = C_READ;
                ENC_WRITE: cmd = C_WRITE;
                ENC_BST: cmd = C_BST;
                ENC_PRE: cmd = C_PRE;
                ENC_REF: cmd = C_REF;
                ENC_MRS: cmd = C_MRS;
                default: cmd = C_NOP;
            endcase
        end
    end
endmodule

// ---- design/sdram_device.sv ----
// Top: SDRAM command interface, banks, bursts, byte masks and init tracking.
`timescale 1ns/100ps
// Function
// (R1) Mode register content is undefined after power; accesses wait for a set.
// (R2) Controller holds no-operation for 200 us before precharging all banks.
// (R3) Controller keeps clock enable and byte masks high during that pause.
// (R4) After all banks are precharged, controller issues a mode register set.
// (R5) Controller issues eight auto refreshes, before or after the mode set.
// (R6) All inputs are sampled only on the rising clock edge; RST_B asserts asynchronously.
// (R7) Row address is lines 0-11 on activate, column lines 0-7 on access.
// (R8) Precharge with line 10 high closes all banks, else the selected one.
// (R9) Two bank select inputs pick the bank for activate, read and write.
// (R10) With chip select high, new commands are ignored, operations continue.
// (R11) Row strobe, column strobe and write enable together encode the command.
// (R12) A byte mask high in a read turns that lane off two cycles later.
// (R13) A byte mask high in a write discards that lane's data at once.
// (R14) Clock enable low stops internal clocking: power down, suspend, refresh.
// (R15) Controller encodes mode set as all four command inputs low.
// (R16) Controller waits the mode set cycle time before its next command.
// (R17) Mask 0 covers data bits 7-0, mask 3 covers bits 31-24.
module sdram_device #(
    parameter int STORE_AW = 22
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic CKE,
    input wire sdram_pkg::cmd_pins_t CMD,
    input wire logic [sdram_pkg::ROW_W-1:0] ADDR,
    input wire logic BANK_SELECT_BIT0,
    input wire logic BANK_SELECT_BIT1,
    input wire logic [sdram_pkg::LANES-1:0] BYTE_LANE_MASKS,
    input wire logic [sdram_pkg::DQ_W-1:0] DQ_IN,
    output logic [sdram_pkg::DQ_W-1:0] DQ_OUT,
    output logic [sdram_pkg::LANES-1:0] DQ_OE_B,
    output logic INIT_DONE,
    output logic POWER_DOWN,
    output logic SELF_REFRESH
);
    import sdram_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Number of beats in a burst for the current mode and direction.
    function automatic logic [BEAT_W-1:0] burst_len(input mode_t m,
                                                    input logic wr);
        logic [BEAT_W-1:0] len;
        len = 9'h1;
        if (wr && m.wr_single) begin
            len = 9'h1;
        end else if (m.bl == BL_FULL) begin
            len = PAGE_LEN;
        end else if (m.bl <= BL_MAX_POW) begin
            len = 9'h1 << m.bl;
        end
        return len;
    endfunction

    // Column of beat k, wrapping inside the burst, in order or interleaved.
    function automatic logic [COL_W-1:0] burst_col(
        input logic [COL_W-1:0] start, input logic [COL_W-1:0] k,
        input logic [BEAT_W-1:0] len, input logic ilv);
        logic [BEAT_W-1:0] lm;
        logic [COL_W-1:0] msk;
        lm = len - 9'h1;
        msk = lm[COL_W-1:0];
        if (ilv) begin
            return start ^ (k & msk);
        end
        return (start & ~msk) | ((start + k) & msk);
    endfunction

    // Storage word for a bank, row and column; upper bits may alias.
    function automatic logic [STORE_AW-1:0] mem_index(
        input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] r,
        input logic [COL_W-1:0] c);
        logic [BANK_W+ROW_W+COL_W-1:0] w;
        w = {b, r, c};
        return w[STORE_AW-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reset release and command decode.

    logic [1:0] rst_q;
    logic rst_b_i;
    dev_state_t st;
    dev_state_t nx;
    cmd_t cmd;
    logic [DQ_W-1:0] mem [0:(1<<STORE_AW)-1];

    // Reset asserts at once and releases through two flip-flops.
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rst_q <= '0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_b_i = rst_q[1];

    cmd_decode u_dec (
        .pins(CMD),
        .cmd(cmd)
    );

    ////////////////////////////////////////////////////////////////////////
    // Access issue logic.

    logic adv;
    logic take;
    logic idle;
    logic [BANK_W-1:0] bank_in;
    logic new_rd;
    logic new_wr;
    logic new_acc;
    logic cur_wr;
    logic iss;
    logic [BANK_W-1:0] iss_bank;
    logic [COL_W-1:0] iss_start;
    logic [COL_W-1:0] iss_k;
    logic [BEAT_W-1:0] blen;
    logic iss_last;
    logic iss_ap;
    logic [STORE_AW-1:0] beat_idx;
    logic wr_beat;
    logic rd_beat;

    // Internal clock runs only when clock enable was high one edge before.
    assign adv = st.cke_q; // [R14]
    assign take = adv && (cmd != C_DESEL); // [R10]
    assign idle = !st.rd_act && !st.wr_act;
    assign bank_in = {BANK_SELECT_BIT1, BANK_SELECT_BIT0}; // [R9]

    // Reads and writes need a defined mode and an open bank.
    assign new_rd = take && cmd == C_READ && st.mode_valid // [R1]
        && st.bank_open[bank_in];
    assign new_wr = take && cmd == C_WRITE && st.mode_valid
        && st.bank_open[bank_in];
    assign new_acc = new_rd || new_wr;
    assign cur_wr = new_acc ? new_wr : st.wr_act;

    // A new access starts at beat 0 and overrides any running burst.
    assign iss = new_acc || (!idle && adv);
    assign iss_bank = new_acc ? bank_in : st.bbank; // [R9]
    assign iss_start = new_acc ? ADDR[COL_W-1:0] : st.bcol; // [R7]
    assign iss_k = new_acc ? '0 : st.beat;
    assign iss_ap = new_acc ? ADDR[PRE_ALL_BIT] : st.bap;
    assign blen = burst_len(st.mode, cur_wr);
    assign iss_last = (blen != PAGE_LEN) && ({1'b0, iss_k} == blen - 9'h1);
    assign beat_idx = mem_index(iss_bank, st.open_row[iss_bank],
        burst_col(iss_start, iss_k, blen, st.mode.ilv));
    assign wr_beat = iss && cur_wr;
    assign rd_beat = iss && !cur_wr;

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        nx = st;
        // Clock enable and masks are taken at every rising edge.
        nx.cke_q = CKE; // [R6]
        nx.dqm_q = BYTE_LANE_MASKS; // [R6]
        if (CKE) begin
            nx.pd = 1'b0;
            nx.sr = 1'b0;
        end
        // Burst progress, with auto precharge on the last beat.
        if (iss) begin
            nx.rd_act = !cur_wr && !iss_last;
            nx.wr_act = cur_wr && !iss_last;
            nx.bbank = iss_bank;
            nx.bcol = iss_start;
            nx.beat = iss_k + 8'h1;
            nx.bap = iss_ap;
            if (iss_last && iss_ap) begin
                nx.bank_open[iss_bank] = 1'b0;
            end
        end
        // Read pipeline, frozen while the internal clock is stopped.
        if (adv) begin
            nx.pv = {st.pv[0], rd_beat};
            nx.pipe[0] = mem[beat_idx];
            nx.pipe[1] = st.pipe[0];
            if (st.mode.cl == CL_TWO) begin
                nx.vout = st.pv[0];
                nx.dout = st.pipe[0];
            end else begin
                nx.vout = st.pv[1];
                nx.dout = st.pipe[1];
            end
        end
        // Lanes drive only for read data that was not masked.
        nx.oe_b = ~{LANES{nx.vout}} | st.dqm_q; // [R12]
        // Commands other than read and write.
        if (take) begin
            case (cmd)
                C_ACT: begin
                    if (!st.bank_open[bank_in]) begin
                        nx.bank_open[bank_in] = 1'b1; // [R9]
                        nx.open_row[bank_in] = ADDR; // [R7]
                    end
                end
                C_PRE: begin
                    if (ADDR[PRE_ALL_BIT]) begin
                        nx.bank_open = '0; // [R8]
                        nx.pre_all_seen = 1'b1;
                    end else begin
                        nx.bank_open[bank_in] = 1'b0; // [R8]
                    end
                    if (ADDR[PRE_ALL_BIT] || bank_in == st.bbank) begin
                        nx.rd_act = 1'b0;
                        nx.wr_act = 1'b0;
                    end
                end
                C_BST: begin
                    nx.rd_act = 1'b0;
                    nx.wr_act = 1'b0;
                end
                C_REF: begin
                    if (idle && st.bank_open == '0) begin
                        if (!CKE) begin
                            nx.sr = 1'b1; // [R14]
                        end else if (st.ref_cnt != INIT_REFRESHES) begin
                            nx.ref_cnt = st.ref_cnt + 4'h1;
                        end
                    end
                end
                C_MRS: begin
                    if (idle && st.bank_open == '0) begin
                        nx.mode.bl = ADDR[MR_BL_LSB +: MR_CODE_W]; // [R1]
                        nx.mode.ilv = ADDR[MR_BT_BIT];
                        nx.mode.cl = ADDR[MR_CL_LSB +: MR_CODE_W];
                        nx.mode.wr_single = ADDR[MR_WB_BIT];
                        nx.mode_valid = 1'b1;
                        nx.mrs_seen = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        // Clock enable falling with no burst and no command: power down.
        if (adv && !CKE && idle && (cmd == C_NOP || cmd == C_DESEL)) begin
            nx.pd = 1'b1; // [R14]
        end
        nx.init_done = nx.pre_all_seen && nx.mrs_seen
            && nx.ref_cnt == INIT_REFRESHES;
    end

    // Whole state in one register; mode is held invalid until set.
    always_ff @(posedge CLOCK or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= ST_RST; // [R1]
        end else begin
            st <= nx; // [R6]
        end
    end

    // Write beats store each unmasked byte lane.
    always_ff @(posedge CLOCK) begin
        if (wr_beat) begin
            for (int l = 0; l < LANES; l++) begin
                if (!BYTE_LANE_MASKS[l]) begin // [R13]
                    mem[beat_idx][LANE_W*l +: LANE_W] <=
                        DQ_IN[LANE_W*l +: LANE_W]; // [R17]
                end
            end
        end
    end

    assign DQ_OUT = st.dout;
    assign DQ_OE_B = st.oe_b;
    assign INIT_DONE = st.init_done;
    assign POWER_DOWN = st.pd;
    assign SELF_REFRESH = st.sr;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    logic [LANE_W-1:0] old_lane0;
    logic [LANE_W-1:0] din_top;
    assign old_lane0 = mem[beat_idx][LANE_W-1:0];
    assign din_top = DQ_IN[DQ_W-1 -: LANE_W];

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!rst_b_i);

    a_mode_set_only: assert property ( // [R1]
        $rose(st.mode_valid) |-> $past(take) && $past(cmd) == C_MRS)
        else $error("Mode became valid without a mode set.");
    a_cs_ignored: assert property ( // [R10]
        CMD.cs_b |=> st.mode == $past(st.mode)
            && st.open_row == $past(st.open_row))
        else $error("Deselected command changed state.");
    a_act_row: assert property ( // [R7]
        take && cmd == C_ACT && !st.bank_open[bank_in]
        |=> st.bank_open[$past(bank_in)]
            && st.open_row[$past(bank_in)] == $past(ADDR))
        else $error("Activate did not latch the row.");
    a_prech_all: assert property ( // [R8]
        take && cmd == C_PRE && ADDR[PRE_ALL_BIT] |=> st.bank_open == '0)
        else $error("Precharge all left a bank open.");
    a_prech_bank: assert property ( // [R8]
        take && cmd == C_PRE && !ADDR[PRE_ALL_BIT]
        |=> !st.bank_open[$past(bank_in)])
        else $error("Precharge left the selected bank open.");
    a_dqm_hiz: assert property ( // [R12]
        BYTE_LANE_MASKS != '0 |-> ##2
            (DQ_OE_B & $past(BYTE_LANE_MASKS, 2)) == $past(BYTE_LANE_MASKS, 2))
        else $error("Masked read lane still driven.");
    a_mask_write: assert property ( // [R13]
        wr_beat && BYTE_LANE_MASKS[0]
        |=> mem[$past(beat_idx)][LANE_W-1:0] == $past(old_lane0))
        else $error("Masked write lane was stored.");
    a_lane3_write: assert property ( // [R17]
        wr_beat && !BYTE_LANE_MASKS[LANES-1]
        |=> mem[$past(beat_idx)][DQ_W-1 -: LANE_W] == $past(din_top))
        else $error("Top lane write not stored.");
    a_suspend_hold: assert property ( // [R14]
        !st.cke_q |=> st.beat == $past(st.beat) && DQ_OUT == $past(DQ_OUT))
        else $error("State moved while clock was stopped.");
    a_read_drive: assert property ( // [R11]
        new_rd && st.mode.cl == CL_TWO && CKE && BYTE_LANE_MASKS == '0
        |-> ##2 DQ_OE_B == '0)
        else $error("Read did not drive data at latency two.");
endmodule

// ---- dv/ctrl_model.sv ----
// Controller model: drives the command pins and runs the power-up sequence.
`timescale 1ns/100ps
module ctrl_model #(
    parameter int PAUSE_CYC = 25000,
    parameter int MODE_SET_CYCLE_TIME = 2
) (
    input wire logic clk,
    output logic cke,
    output sdram_pkg::cmd_pins_t cmd,
    output logic [sdram_pkg::ROW_W-1:0] addr,
    output logic bank_select_bit0,
    output logic bank_select_bit1,
    output logic [sdram_pkg::LANES-1:0] byte_lane_masks,
    output logic [sdram_pkg::DQ_W-1:0] dq
);
    import sdram_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // All pins start idle and deselected, with every lane masked.
    initial begin
        cke = 1'b1;
        cmd = 4'hf;
        addr = 12'h000;
        {bank_select_bit1, bank_select_bit0} = 2'h0;
        byte_lane_masks = 4'hf;
        dq = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One command cycle: called at a falling edge, held to the next one.
    task automatic cyc(input logic cs_b, input logic [2:0] enc,
        input logic [1:0] bank, input logic [ROW_W-1:0] a,
        input logic [LANES-1:0] m, input logic [DQ_W-1:0] d,
        input logic ck);
        cmd = {cs_b, enc};
        addr = a;
        {bank_select_bit1, bank_select_bit0} = bank;
        byte_lane_masks = m;
        dq = d;
        cke = ck;
        @(negedge clk);
    endtask

    // Command with clock enable high; the data lines toggle every cycle.
    task automatic op(input logic cs_b, input logic [2:0] enc,
        input logic [1:0] bank, input logic [ROW_W-1:0] a,
        input logic [LANES-1:0] m);
        cyc(cs_b, enc, bank, a, m, ~dq, 1'b1);
    endtask

    // Plain no-operation cycle.
    task automatic nop();
        op(1'b0, ENC_NOP, 2'h0, 12'h000, 4'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Pause with NOP, clock enable and masks high, then precharge all.
    task automatic power_up();
        repeat (PAUSE_CYC) begin
            cyc(1'b0, ENC_NOP, 2'h0, 12'h000, 4'hf, ~dq, 1'b1);
        end
        op(1'b0, ENC_PRE, 2'h0, 12'h400, 4'h0);
    endtask

    // Mode set is all four command pins low, then the set cycle time idles.
    task automatic mode_set(input logic [ROW_W-1:0] a);
        op(1'b0, ENC_MRS, 2'h0, a, 4'h0);
        repeat (MODE_SET_CYCLE_TIME) begin
            nop();
        end
    endtask

    // One auto refresh followed by an idle cycle.
    task automatic refresh();
        op(1'b0, ENC_REF, 2'h0, 12'h000, 4'h0);
        nop();
    endtask
endmodule

// ---- dv/tb_top.sv ----
// Testbench: init sequence, bank access, byte masks, deselect, power modes.
`timescale 1ns/100ps
module tb_top;
    import sdram_pkg::*;

    logic clock;
    logic rst_b;
    logic cke;
    cmd_pins_t cmd;
    logic [ROW_W-1:0] addr;
    logic bs0;
    logic bs1;
    logic [LANES-1:0] masks;
    logic [DQ_W-1:0] ctl_dq;
    logic [DQ_W-1:0] dq_wire;
    logic [DQ_W-1:0] dq_out;
    logic [LANES-1:0] dq_oe_b;
    logic init_done;
    logic power_down;
    logic self_refresh;
    int err_count;
    int tests_run;
    int cycles;

    ////////////////////////////////////////////////////////////////////////
    // Clock at 125 MHz.
    always #4 clock = ~clock;

    // Each lane of the shared data bus shows whichever side drives it.
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            dq_wire[i*LANE_W +: LANE_W] = dq_oe_b[i] ?
                ctl_dq[i*LANE_W +: LANE_W] : dq_out[i*LANE_W +: LANE_W];
        end
    end

    ctrl_model #(.PAUSE_CYC(25000), .MODE_SET_CYCLE_TIME(2)) ctl (
        .clk(clock), .cke(cke), .cmd(cmd), .addr(addr),
        .bank_select_bit0(bs0), .bank_select_bit1(bs1),
        .byte_lane_masks(masks), .dq(ctl_dq));

    sdram_device #(.STORE_AW(10)) DUT (
        .CLOCK(clock), .RST_B(rst_b), .CKE(cke), .CMD(cmd), .ADDR(addr),
        .BANK_SELECT_BIT0(bs0), .BANK_SELECT_BIT1(bs1),
        .BYTE_LANE_MASKS(masks), .DQ_IN(dq_wire), .DQ_OUT(dq_out),
        .DQ_OE_B(dq_oe_b), .INIT_DONE(init_done),
        .POWER_DOWN(power_down), .SELF_REFRESH(self_refresh));

    ////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Compares one value and reports a difference at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // A hang is cut short well after the power-up pause should be over.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            $display("Cycle limit reached at %0t", $time);
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Burst of two at latency three; a deselected write sits in the second
    // cycle, and mask m is raised two edges before the second word.
    task automatic rd(input logic [1:0] b, input logic [ROW_W-1:0] a,
        input logic [31:0] e0, input logic [31:0] e1,
        input logic [LANES-1:0] m, input logic none);
        logic [31:0] keep;
        keep = ~{{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
        ctl.op(1'b0, ENC_READ, b, a, 4'h0);
        ctl.op(1'b1, ENC_WRITE, b, 12'h000, 4'h0);
        ctl.op(1'b0, ENC_NOP, 2'h0, 12'h000, m);
        chk(32'(dq_oe_b), none ? 32'hf : 32'h0);
        if (!none) begin
            chk(dq_out, e0);
        end
        ctl.nop();
        chk(32'(dq_oe_b), none ? 32'hf : 32'(m));
        if (!none) begin
            chk(dq_out & keep, e1 & keep);
        end
        ctl.nop();
        chk(32'(dq_oe_b), 32'hf);
    endtask

    // Outputs stay quiet while reset is held.
    task automatic t_reset();
        chk(32'(dq_oe_b), 32'hf);
        chk(32'(init_done), 32'h0);
        chk(32'({power_down, self_refresh}), 32'h0);
    endtask

    // Power-up, a read refused before the mode set, then the refresh count.
    task automatic t_init();
        ctl.power_up();
        ctl.op(1'b0, ENC_ACT, 2'h0, 12'h000, 4'h0);
        rd(2'h0, 12'h000, 32'h0, 32'h0, 4'h0, 1'b1);
        ctl.op(1'b0, ENC_PRE, 2'h0, 12'h400, 4'h0);
        ctl.mode_set(12'h031);
        repeat (7) ctl.refresh();
        ctl.nop();
        chk(32'(init_done), 32'h0);
        ctl.refresh();
        ctl.nop();
        chk(32'(init_done), 32'h1);
    endtask

    // Two banks open on different rows; the third write has lane masks on both beats.
    task automatic t_write();
        ctl.op(1'b0, ENC_ACT, 2'h1, 12'h001, 4'h0);
        ctl.op(1'b0, ENC_ACT, 2'h2, 12'h002, 4'h0);
        ctl.cyc(1'b0, ENC_WRITE, 2'h1, 12'h104, 4'h0, 32'h11223344, 1'b1);
        ctl.cyc(1'b0, ENC_NOP, 2'h0, 12'h000, 4'h0, 32'h55667788, 1'b1);
        ctl.cyc(1'b0, ENC_WRITE, 2'h2, 12'h004, 4'h0, 32'haabbccdd, 1'b1);
        ctl.cyc(1'b0, ENC_NOP, 2'h0, 12'h000, 4'h0, 32'h01020304, 1'b1);
        ctl.cyc(1'b0, ENC_WRITE, 2'h2, 12'h004, 4'h8, 32'hdeadbeef, 1'b1);
        ctl.cyc(1'b0, ENC_NOP, 2'h0, 12'h000, 4'h3, 32'hf0e0d0c0, 1'b1);
        ctl.nop();
        rd(2'h1, 12'h004, 32'h11223344, 32'h55667788, 4'h1, 1'b0);
        rd(2'h2, 12'h004, 32'haaadbeef, 32'hf0e00304, 4'h0, 1'b0);
    endtask

    // Closing one bank leaves the other readable.
    task automatic t_precharge();
        ctl.op(1'b0, ENC_PRE, 2'h2, 12'h000, 4'h0);
        ctl.nop();
        rd(2'h2, 12'h004, 32'h0, 32'h0, 4'h0, 1'b1);
        rd(2'h1, 12'h004, 32'h11223344, 32'h55667788, 4'h0, 1'b0);
    endtask

    // Clock enable low enters power down, or self refresh with a refresh.
    task automatic t_power();
        ctl.op(1'b0, ENC_PRE, 2'h0, 12'h400, 4'h0);
        ctl.cyc(1'b0, ENC_NOP, 2'h0, 12'h000, 4'h0, ~ctl_dq, 1'b0);
        ctl.cyc(1'b0, ENC_NOP, 2'h0, 12'h000, 4'h0, ~ctl_dq, 1'b0);
        chk(32'({power_down, self_refresh}), 32'h2);
        ctl.nop();
        ctl.nop();
        chk(32'({power_down, self_refresh}), 32'h0);
        ctl.cyc(1'b0, ENC_REF, 2'h0, 12'h000, 4'h0, ~ctl_dq, 1'b0);
        ctl.cyc(1'b0, ENC_NOP, 2'h0, 12'h000, 4'h0, ~ctl_dq, 1'b0);
        chk(32'({power_down, self_refresh}), 32'h1);
        ctl.nop();
        ctl.nop();
        chk(32'({power_down, self_refresh}), 32'h0);
    endtask

    // Latency two with interleave, single writes, then auto precharge.
    task automatic t_cl2();
        ctl.mode_set(12'h229);
        ctl.op(1'b0, ENC_ACT, 2'h1, 12'h001, 4'h0);
        ctl.cyc(1'b0, ENC_WRITE, 2'h1, 12'h005, 4'h0, 32'hcafe0001, 1'b1);
        ctl.cyc(1'b0, ENC_NOP, 2'h0, 12'h000, 4'h0, 32'h0bad0002, 1'b1);
        ctl.op(1'b0, ENC_READ, 2'h1, 12'h405, 4'h0);
        ctl.nop();
        chk(32'(dq_oe_b), 32'h0);
        chk(dq_out, 32'hcafe0001);
        ctl.nop();
        chk(32'(dq_oe_b), 32'h0);
        chk(dq_out, 32'h11223344);
        ctl.op(1'b0, ENC_READ, 2'h1, 12'h005, 4'h0);
        ctl.nop();
        chk(32'(dq_oe_b), 32'hf);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        err_count = 0;
        tests_run = 0;
        cycles = 0;
        repeat (5) @(negedge clock);
        t_reset();
        rst_b = 1'b1;
        t_init();
        t_write();
        t_precharge();
        t_power();
        t_cl2();
        stop_test();
    end
endmodule
